// File: logic/lmdsa_alu.sv
// Top of the logic, multiply, divide and shift datapath
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module lmdsa_alu (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [2:0] op_i,
    input wire logic byte_i,
    input wire logic reg_odd_i,
    input wire logic [15:0] src_i,
    input wire logic [15:0] dst_i,
    input wire logic [15:0] pair_i,
    input wire logic n_i,
    input wire logic z_i,
    input wire logic v_i,
    input wire logic c_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic busy_o,
    output logic done_o,
    output logic refused_o,
    output logic [15:0] res_hi_o,
    output logic [15:0] res_lo_o,
    output logic wr_hi_o,
    output logic wr_lo_o,
    output logic n_o,
    output logic z_o,
    output logic v_o,
    output logic c_o,
    output logic [15:0] reg_rdata_o
);
    // ************************************************************
    // Declarations
    // ************************************************************
    lmdsa_pkg::lmdsa_op_t op;
    logic start_ok, eis_en, refuse, go_div, abort;
    logic [15:0] r_hi, r_lo, lw, dsr_mag;
    logic w_hi, w_lo, fn, fz, fv, fc;
    logic [31:0] prod, dvd, dvd_mag, sh_x, sh_res;
    logic sh_c, sh_v, sh_half, div_done;
    logic [15:0] quot_mag, rem_mag, q_fin, r_fin;
    logic busy_q, dvd_neg_q, quo_neg_q, done_q, refused_q, ref_last_q;
    logic [15:0] hi_q, lo_q, ctrl_q, rdata_q;
    logic whi_q, wlo_q, n_q, z_q, v_q, c_q, abort_q;

    function automatic logic [15:0] neg16(input logic [15:0] a);
        return ~a + 16'h0001;
    endfunction

    function automatic logic is_eis(input lmdsa_pkg::lmdsa_op_t o);
        return o == lmdsa_pkg::OP_XOR || o == lmdsa_pkg::OP_PRODUCT ||
               o == lmdsa_pkg::OP_DIVIDE ||
               o == lmdsa_pkg::OP_ARITH_SHIFT ||
               o == lmdsa_pkg::OP_DOUBLE_SHIFT;
    endfunction

    assign op = lmdsa_pkg::lmdsa_op_t'(op_i);
    assign start_ok = start_i && !busy_q;
    assign eis_en = ctrl_q[lmdsa_pkg::CTRL_EIS_BIT];
    assign refuse = !eis_en && is_eis(op);

    // ************************************************************
    // Operand preparation
    // ************************************************************
    assign prod = 32'($signed(dst_i)) * 32'($signed(src_i));
    assign dvd = {dst_i, pair_i};
    assign dvd_mag = dvd[31] ? (~dvd + 32'h0000_0001) : dvd;
    assign dsr_mag = src_i[15] ? neg16(src_i) : src_i;
    assign sh_half = (op == lmdsa_pkg::OP_ARITH_SHIFT);

    always_comb begin
        sh_x = {dst_i, pair_i};
        if (op == lmdsa_pkg::OP_ARITH_SHIFT) begin
            sh_x = {dst_i, 16'h0000};
        end else if (reg_odd_i) begin
            sh_x = {dst_i, dst_i};
        end
    end

    lmdsa_shift u_shift (
        .x_i(sh_x),
        .cnt_i(src_i[lmdsa_pkg::CNT_W-1:0]),
        .half_i(sh_half),
        .res_o(sh_res),
        .c_o(sh_c),
        .v_o(sh_v)
    );

    lmdsa_div #(
        .W(lmdsa_pkg::DIV_STEPS)
    ) u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(go_div),
        .dividend_i(dvd_mag),
        .divisor_i(dsr_mag),
        .done_o(div_done),
        .quot_o(quot_mag),
        .rem_o(rem_mag)
    );

    assign q_fin = quo_neg_q ? neg16(quot_mag) : quot_mag;
    assign r_fin = dvd_neg_q ? neg16(rem_mag) : rem_mag;

    // ************************************************************
    // Result and flag selection
    // ************************************************************
    always_comb begin
        r_hi = dst_i;
        r_lo = pair_i;
        w_hi = 1'b0;
        w_lo = 1'b0;
        fn = n_i;
        fz = z_i;
        fv = v_i;
        fc = c_i;
        abort = 1'b0;
        go_div = 1'b0;
        lw = 16'h0000;
        unique case (op)
            lmdsa_pkg::OP_CLEAR_BITS, lmdsa_pkg::OP_SET_BITS: begin
                lw = (op == lmdsa_pkg::OP_CLEAR_BITS) ?
                     (~src_i & dst_i) : (src_i | dst_i);
                w_hi = 1'b1;
                fv = 1'b0;
                if (byte_i) begin
                    r_hi = {dst_i[15:8], lw[7:0]};
                    fn = lw[7];
                    fz = (lw[7:0] == 8'h00);
                end else begin
                    r_hi = lw;
                    fn = lw[15];
                    fz = (lw == 16'h0000);
                end
            end
            lmdsa_pkg::OP_XOR: begin
                r_hi = src_i ^ dst_i;
                w_hi = 1'b1;
                fn = r_hi[15];
                fz = (r_hi == 16'h0000);
                fv = 1'b0;
            end
            lmdsa_pkg::OP_PRODUCT: begin
                w_hi = 1'b1;
                if (reg_odd_i) begin
                    r_hi = prod[15:0];
                end else begin
                    r_hi = prod[31:16];
                    r_lo = prod[15:0];
                    w_lo = 1'b1;
                end
                fn = prod[31];
                fz = (prod == 32'h0000_0000);
                fv = 1'b0;
                fc = (prod[31:15] != {17{prod[31]}});
            end
            lmdsa_pkg::OP_DIVIDE: begin
                if (src_i == 16'h0000 ||
                    dvd_mag[31:lmdsa_pkg::QUO_BITS] >= {1'b0, dsr_mag}) begin
                    abort = 1'b1;
                    fv = 1'b1;
                    fc = (src_i == 16'h0000);
                    fn = 1'b0;
                    fz = 1'b0;
                end else begin
                    go_div = start_ok && !refuse;
                end
            end
            lmdsa_pkg::OP_ARITH_SHIFT: begin
                r_hi = sh_res[31:16];
                w_hi = 1'b1;
                fn = r_hi[15];
                fz = (r_hi == 16'h0000);
                fv = sh_v;
                fc = sh_c;
            end
            lmdsa_pkg::OP_DOUBLE_SHIFT: begin
                w_hi = 1'b1;
                if (reg_odd_i) begin
                    r_hi = sh_res[15:0];
                end else begin
                    r_hi = sh_res[31:16];
                    r_lo = sh_res[15:0];
                    w_lo = 1'b1;
                end
                fn = sh_res[31];
                fz = (sh_res == 32'h0000_0000);
                fv = sh_v;
                fc = sh_c;
            end
            default: begin
                w_hi = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Divide sequencing
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            dvd_neg_q <= 1'b0;
            quo_neg_q <= 1'b0;
        end else if (go_div) begin
            busy_q <= 1'b1;
            dvd_neg_q <= dvd[31];
            quo_neg_q <= dvd[31] ^ src_i[15];
        end else if (div_done) begin
            busy_q <= 1'b0;
        end
    end

    // ************************************************************
    // Result registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
            hi_q <= 16'h0000;
            lo_q <= 16'h0000;
            whi_q <= 1'b0;
            wlo_q <= 1'b0;
            n_q <= 1'b0;
            z_q <= 1'b0;
            v_q <= 1'b0;
            c_q <= 1'b0;
            abort_q <= 1'b0;
            ref_last_q <= 1'b0;
        end else if (div_done) begin
            done_q <= 1'b1;
            refused_q <= 1'b0;
            hi_q <= q_fin;
            lo_q <= r_fin;
            whi_q <= 1'b1;
            wlo_q <= 1'b1;
            n_q <= q_fin[15];
            z_q <= (q_fin == 16'h0000);
            v_q <= 1'b0;
            c_q <= 1'b0;
            abort_q <= 1'b0;
            ref_last_q <= 1'b0;
        end else if (start_ok && refuse) begin
            done_q <= 1'b1;
            refused_q <= 1'b1;
            whi_q <= 1'b0;
            wlo_q <= 1'b0;
            n_q <= n_i;
            z_q <= z_i;
            v_q <= v_i;
            c_q <= c_i;
            abort_q <= 1'b0;
            ref_last_q <= 1'b1;
        end else if (start_ok && !go_div) begin
            done_q <= 1'b1;
            refused_q <= 1'b0;
            hi_q <= r_hi;
            lo_q <= r_lo;
            whi_q <= w_hi;
            wlo_q <= w_lo;
            n_q <= fn;
            z_q <= fz;
            v_q <= fv;
            c_q <= fc;
            abort_q <= abort;
            ref_last_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
            whi_q <= 1'b0;
            wlo_q <= 1'b0;
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= lmdsa_pkg::CTRL_RST;
        end else if (reg_we_i && reg_addr_i == lmdsa_pkg::REG_CTRL) begin
            ctrl_q <= {15'h0000, reg_wdata_i[lmdsa_pkg::CTRL_EIS_BIT]};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 16'h0000;
        end else if (reg_re_i && reg_addr_i == lmdsa_pkg::REG_CTRL) begin
            rdata_q <= ctrl_q;
        end else if (reg_re_i && reg_addr_i == lmdsa_pkg::REG_STAT) begin
            rdata_q <= 16'h0000;
            rdata_q[lmdsa_pkg::STAT_BUSY_BIT] <= busy_q;
            rdata_q[lmdsa_pkg::STAT_ABORT_BIT] <= abort_q;
            rdata_q[lmdsa_pkg::STAT_REFUSED_BIT] <= ref_last_q;
            rdata_q[lmdsa_pkg::STAT_FLAGS_LSB+:4] <= {n_q, z_q, v_q, c_q};
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign refused_o = refused_q;
    assign res_hi_o = hi_q;
    assign res_lo_o = lo_q;
    assign wr_hi_o = whi_q;
    assign wr_lo_o = wlo_q;
    assign n_o = n_q;
    assign z_o = z_q;
    assign v_o = v_q;
    assign c_o = c_q;
    assign reg_rdata_o = rdata_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    clear_bits_a: assert property (
        start_ok && !refuse && op == lmdsa_pkg::OP_CLEAR_BITS && !byte_i
        |=> res_hi_o == ($past(~src_i) & $past(dst_i)) && wr_hi_o && !v_o)
        else $error("clear bits result wrong");
    set_bits_a: assert property (
        start_ok && !refuse && op == lmdsa_pkg::OP_SET_BITS && !byte_i
        |=> res_hi_o == ($past(src_i) | $past(dst_i)) && c_o == $past(c_i))
        else $error("set bits result wrong");
    byte_upper_a: assert property (
        start_ok && !refuse && byte_i && op == lmdsa_pkg::OP_SET_BITS
        |=> res_hi_o[15:8] == $past(dst_i[15:8]) && n_o == res_hi_o[7])
        else $error("byte operation touched upper byte");
    mul_carry_a: assert property (
        start_ok && !refuse && op == lmdsa_pkg::OP_PRODUCT
        |=> c_o == ($past(prod[31:15]) != {17{$past(prod[31])}})
            && wr_lo_o == !$past(reg_odd_i))
        else $error("multiply carry or write wrong");
    div_zero_a: assert property (
        start_ok && !refuse && op == lmdsa_pkg::OP_DIVIDE && src_i == 16'h0000
        |=> v_o && c_o && !wr_hi_o && !wr_lo_o && done_o)
        else $error("divide by zero not aborted");
    div_latency_a: assert property (
        go_div |=> (busy_o && !done_o) [*8] ##8 busy_o ##1 busy_o
        ##1 (done_o && wr_lo_o && !busy_o))
        else $error("divide latency wrong");
    rem_sign_a: assert property (
        div_done && r_fin != 16'h0000 |=> res_lo_o[15] == dvd_neg_q)
        else $error("remainder sign differs from dividend");
    ash_right_a: assert property (
        start_ok && !refuse && op == lmdsa_pkg::OP_ARITH_SHIFT && src_i[5]
        |=> !v_o && res_hi_o[15] == $past(dst_i[15]))
        else $error("right shift changed sign");
    xor_flags_a: assert property (
        start_ok && !refuse && op == lmdsa_pkg::OP_XOR
        |=> !v_o && c_o == $past(c_i) && z_o == (res_hi_o == 16'h0000))
        else $error("exclusive or flags wrong");

    div_done_c: cover property (div_done ##1 done_o);
    shift_ovf_c: cover property (done_o && v_o && wr_hi_o);
    rotate_c: cover property (
        start_ok && op == lmdsa_pkg::OP_DOUBLE_SHIFT && reg_odd_i && src_i[5]);
endmodule

// File: logic/lmdsa_pkg.sv
// Constants and types for the logic, multiply, divide and shift datapath
package lmdsa_pkg;

    // ************************************************************
    // Widths and timing
    // ************************************************************
    localparam int DATA_W = 16;
    localparam int CNT_W = 6;
    localparam int DIV_STEPS = 16;
    localparam int QUO_BITS = 15;
    localparam int REG_ADDR_W = 2;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STAT = 2'h1;
    localparam int CTRL_EIS_BIT = 0;
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ABORT_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int STAT_FLAGS_LSB = 4;

    // ************************************************************
    // Operations
    // ************************************************************
    typedef enum logic [2:0] {
        OP_CLEAR_BITS = 3'b000,
        OP_SET_BITS = 3'b001,
        OP_XOR = 3'b010,
        OP_PRODUCT = 3'b011,
        OP_DIVIDE = 3'b100,
        OP_ARITH_SHIFT = 3'b101,
        OP_DOUBLE_SHIFT = 3'b110
    } lmdsa_op_t;

endpackage

// File: logic/lmdsa_shift.sv
// Arithmetic shifter for single and combined register shifts
`timescale 1ns/100ps
module lmdsa_shift (
    input wire logic [31:0] x_i,
    input wire logic [5:0] cnt_i,
    input wire logic half_i,
    output logic [31:0] res_o,
    output logic c_o,
    output logic v_o
);
    logic [63:0] pl;
    logic [32:0] pr;
    logic [5:0] k;

    always_comb begin
        k = 6'h00;
        pl = 64'h0;
        pr = 33'h0;
        res_o = x_i;
        c_o = 1'b0;
        v_o = 1'b0;
        if (cnt_i[5]) begin
            k = ~cnt_i + 6'h01;
            pr = $signed({x_i, 1'b0}) >>> k;
            res_o = pr[32:1];
            c_o = half_i ? pr[16] : pr[0];
        end else if (cnt_i != 6'h00) begin
            k = cnt_i;
            pl = {32'h0, x_i} << k;
            res_o = pl[31:0];
            c_o = pl[32];
            // Sign changed if shifting back cannot recover the operand
            v_o = (($signed(pl[31:0]) >>> k) != $signed(x_i));
        end
    end
endmodule

// File: logic/lmdsa_div.sv
// Iterative restoring divider for unsigned magnitudes
`timescale 1ns/100ps
module lmdsa_div #(
    parameter int W = lmdsa_pkg::DIV_STEPS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [2*W-1:0] dividend_i,
    input wire logic [W-1:0] divisor_i,
    output logic done_o,
    output logic [W-1:0] quot_o,
    output logic [W-1:0] rem_o
);
    logic [W-1:0] rem_q;
    logic [W-1:0] lo_q;
    logic [W-1:0] dsr_q;
    logic [5:0] cnt_q;
    logic done_q;
    logic [W:0] trial;
    logic [W:0] diff;

    if (W < 2 || W > 32) begin : g_bad_width
        $error("divider width out of range");
    end

    assign trial = {rem_q, lo_q[W-1]};
    assign diff = trial - {1'b0, dsr_q};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rem_q <= '0;
            lo_q <= '0;
            dsr_q <= '0;
            cnt_q <= 6'h00;
            done_q <= 1'b0;
        end else if (start_i) begin
            rem_q <= dividend_i[2*W-1:W];
            lo_q <= dividend_i[W-1:0];
            dsr_q <= divisor_i;
            cnt_q <= 6'(W);
            done_q <= 1'b0;
        end else begin
            done_q <= (cnt_q == 6'h01);
            if (cnt_q != 6'h00) begin
                cnt_q <= cnt_q - 6'h01;
                if (trial >= {1'b0, dsr_q}) begin
                    rem_q <= diff[W-1:0];
                    lo_q <= {lo_q[W-2:0], 1'b1};
                end else begin
                    rem_q <= trial[W-1:0];
                    lo_q <= {lo_q[W-2:0], 1'b0};
                end
            end
        end
    end

    assign done_o = done_q;
    assign quot_o = lo_q;
    assign rem_o = rem_q;
endmodule

// File: dv/lmdsa_regfile.sv
// Register file and flag store standing in for the processor's decode side
`timescale 1ns/100ps
module lmdsa_regfile (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ld_i,
    input wire logic [2:0] idx_i,
    input wire logic [31:0] ld_val_i,
    input wire logic done_i,
    input wire logic wr_hi_i,
    input wire logic wr_lo_i,
    input wire logic [15:0] res_hi_i,
    input wire logic [15:0] res_lo_i,
    input wire logic [3:0] flags_i,
    output logic [15:0] r_o,
    output logic [15:0] pair_o,
    output logic [3:0] flags_o
);
    logic [15:0] regs_q [8];
    logic [2:0] odd_idx;

    assign odd_idx = idx_i | 3'h1;
    assign r_o = regs_q[idx_i];
    assign pair_o = regs_q[odd_idx];

    // Named register written last so it wins when both halves coincide
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                regs_q[i] <= 16'h0000;
            end
        end else if (ld_i) begin
            regs_q[odd_idx] <= ld_val_i[15:0];
            regs_q[idx_i] <= ld_val_i[31:16];
        end else begin
            if (wr_lo_i) begin
                regs_q[odd_idx] <= res_lo_i;
            end
            if (wr_hi_i) begin
                regs_q[idx_i] <= res_hi_i;
            end
        end
    end

    // Flags fed back to the datapath, so untouched carry shows up
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_o <= 4'h0;
        end else if (done_i) begin
            flags_o <= flags_i;
        end
    end
endmodule

// File: dv/test_lmdsa_alu.sv
// Self-checking bench for the logic, multiply, divide and shift datapath
`timescale 1ns/100ps
`define CHK(a, b) begin \
    n_tests++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("unexpected at %0t: got %h expected %h", $time, a, b); \
    end \
end
module test_lmdsa_alu;
    localparam logic [2:0] O_CLR = lmdsa_pkg::OP_CLEAR_BITS;
    localparam logic [2:0] O_SET = lmdsa_pkg::OP_SET_BITS;
    localparam logic [2:0] O_XOR = lmdsa_pkg::OP_XOR;
    localparam logic [2:0] O_PRD = lmdsa_pkg::OP_PRODUCT;
    localparam logic [2:0] O_DIV = lmdsa_pkg::OP_DIVIDE;
    localparam logic [2:0] O_SH1 = lmdsa_pkg::OP_ARITH_SHIFT;
    localparam logic [2:0] O_SH2 = lmdsa_pkg::OP_DOUBLE_SHIFT;
    logic clk_i, rst_n_i, start_i, byte_i, reg_we_i, reg_re_i;
    logic [2:0] op_i, idx_q;
    logic [15:0] src_i, reg_wdata_i, reg_rdata_o, r_w, pair_w;
    logic [1:0] reg_addr_i;
    logic ld, byte_q, ref_q;
    logic [31:0] ld_val;
    logic busy_o, done_o, refused_o, wr_hi_o, wr_lo_o, n_o, z_o, v_o, c_o;
    logic [15:0] res_hi_o, res_lo_o;
    logic [3:0] fl_w;
    int failures = 0;
    int n_tests = 0;

    lmdsa_alu u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
        .op_i(op_i), .byte_i(byte_i), .reg_odd_i(idx_q[0]), .src_i(src_i),
        .dst_i(r_w), .pair_i(pair_w), .n_i(fl_w[3]), .z_i(fl_w[2]),
        .v_i(fl_w[1]), .c_i(fl_w[0]), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .busy_o(busy_o), .done_o(done_o), .refused_o(refused_o),
        .res_hi_o(res_hi_o), .res_lo_o(res_lo_o), .wr_hi_o(wr_hi_o),
        .wr_lo_o(wr_lo_o), .n_o(n_o), .z_o(z_o), .v_o(v_o), .c_o(c_o),
        .reg_rdata_o(reg_rdata_o));

    lmdsa_regfile u_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .ld_i(ld),
        .idx_i(idx_q), .ld_val_i(ld_val), .done_i(done_o), .wr_hi_i(wr_hi_o),
        .wr_lo_i(wr_lo_o), .res_hi_i(res_hi_o), .res_lo_i(res_lo_o),
        .flags_i({n_o, z_o, v_o, c_o}), .r_o(r_w), .pair_o(pair_w),
        .flags_o(fl_w));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Load operands, issue one operation, check flags and write-back
    task automatic run(input logic [2:0] op, input int idx,
        input logic [15:0] s, input logic [31:0] v, input logic [31:0] e,
        input logic [3:0] f);
        int k;
        int lat;
        lat = (op == O_DIV && f[1] !== 1'b1) ? 18 : 1;
        @(posedge clk_i);
        ld <= 1'b1;
        idx_q <= idx[2:0];
        ld_val <= v;
        @(posedge clk_i);
        ld <= 1'b0;
        start_i <= 1'b1;
        op_i <= op;
        src_i <= s;
        byte_i <= byte_q;
        @(posedge clk_i);
        start_i <= 1'b0;
        k = 1;
        @(negedge clk_i);
        while (done_o !== 1'b1 && k < 40) begin
            if (k == 9) `CHK(busy_o, 1'b1)
            @(negedge clk_i);
            k++;
        end
        if (k >= 40) begin
            failures++;
            end_of_test();
        end
        `CHK(k, lat)
        `CHK({n_o, z_o, v_o, c_o}, f)
        ref_q = refused_o;
        if (idx_q[0]) `CHK(wr_lo_o, 1'b0)
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK(r_w, e[31:16])
        if (!idx_q[0]) `CHK(pair_w, e[15:0])
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask

    task automatic t_logic();
        run(O_PRD, 0, 16'h7FFF, 32'h7FFF0000, 32'h3FFF0001, 4'h1);
        run(O_CLR, 4, 16'h029C, 32'h02490000, 32'h00410000, 4'h1);
        run(O_SET, 4, 16'h029C, 32'h02490000, 32'h02DD0000, 4'h1);
        byte_q = 1'b1;
        run(O_SET, 4, 16'h0080, 32'h12000000, 32'h12800000, 4'h9);
        run(O_CLR, 4, 16'h00FF, 32'h12FF0000, 32'h12000000, 4'h5);
        byte_q = 1'b0;
        run(O_XOR, 4, 16'h029C, 32'h02490000, 32'h00D50000, 4'h1);
    endtask

    // Extended ops disabled, status, unmapped place
    task automatic t_regs();
        logic [15:0] d;
        rd(2'h0, d);
        `CHK(d, 16'h0001)
        wr(2'h0, 16'h0000);
        run(O_XOR, 4, 16'h029C, 32'h02490000, 32'h02490000, 4'h1);
        `CHK(ref_q, 1'b1)
        rd(2'h1, d);
        `CHK(d[2], 1'b1)
        `CHK(d[7:4], 4'h1)
        wr(2'h3, 16'hFFFF);
        wr(2'h0, 16'h0001);
        rd(2'h3, d);
        `CHK(d, 16'h0000)
        rd(2'h0, d);
        `CHK(d, 16'h0001)
    endtask

    task automatic t_mul();
        run(O_PRD, 1, 16'h0008, 32'h01000000, 32'h08000000, 4'h0);
        run(O_PRD, 2, 16'h0001, 32'hFFFF0000, 32'hFFFFFFFF, 4'h8);
        run(O_PRD, 2, 16'h0002, 32'h40000000, 32'h00008000, 4'h1);
    endtask

    task automatic t_div();
        run(O_DIV, 0, 16'h0002, 32'h00002001, 32'h10000001, 4'h0);
        run(O_DIV, 0, 16'h0002, 32'hFFFFFFF9, 32'hFFFDFFFF, 4'h8);
        run(O_DIV, 0, 16'h0000, 32'h00000005, 32'h00000005, 4'h3);
        run(O_DIV, 0, 16'h0001, 32'h00010000, 32'h00010000, 4'h2);
    endtask

    task automatic t_shift();
        run(O_SH1, 3, 16'hFFC3, 32'h029C0000, 32'h14E00000, 4'h0);
        run(O_SH1, 3, 16'h003F, 32'h80010000, 32'hC0000000, 4'h9);
        run(O_SH1, 3, 16'h0001, 32'h40000000, 32'h80000000, 4'hA);
        run(O_SH1, 3, 16'h0020, 32'h80000000, 32'hFFFF0000, 4'h9);
        run(O_SH2, 2, 16'h0001, 32'h00018000, 32'h00030000, 4'h0);
        run(O_SH2, 2, 16'h003F, 32'h00000001, 32'h00000000, 4'h5);
        run(O_SH2, 3, 16'h003F, 32'h00010000, 32'h80000000, 4'h1);
    endtask

    initial begin
        rst_n_i = 1'b0;
        start_i = 1'b0;
        op_i = 3'h0;
        byte_i = 1'b0;
        src_i = 16'h0000;
        reg_addr_i = 2'h0;
        reg_wdata_i = 16'h0000;
        reg_we_i = 1'b0;
        reg_re_i = 1'b0;
        ld = 1'b0;
        idx_q = 3'h0;
        ld_val = 32'h00000000;
        byte_q = 1'b0;
        ref_q = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_logic();
        t_regs();
        t_mul();
        t_div();
        t_shift();
        end_of_test();
    end
endmodule
